// [ddp_cpu_model.sv]
`timescale 1ns/1ns
// cpu core side: one request per clock, sfr access and pointer op can share a cycle
module ddp_cpu_model
  import ddp_pkg::*;
(
  input wire logic i_clk,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output ddp_op_type o_op,
  output logic [15:0] o_imm,
  output logic [7:0] o_acc
);
  // idle at time zero
  initial
  begin
    {o_wr, o_rd, o_addr, o_wdata, o_imm, o_acc} = '0;
    o_op = DDP_OP_NONE;
  end
  // one request launched at a rising edge, held until the next call
  task automatic cyc(input logic w, input logic r, input logic [7:0] a,
    input logic [7:0] d, input ddp_op_type o, input logic [15:0] m,
    input logic [7:0] c);
    @(posedge i_clk);
    o_wr <= w;
    o_rd <= r;
    o_addr <= a;
    o_wdata <= d;
    o_op <= o;
    o_imm <= m;
    o_acc <= c;
  endtask
endmodule

// [ddp_pkg.sv]
package ddp_pkg;
  // sfr addresses of the pointer unit
  localparam logic [7:0] DDP_ADDR_P0_LO = 8'h82;
  localparam logic [7:0] DDP_ADDR_P0_HI = 8'h83;
  localparam logic [7:0] DDP_ADDR_P1_LO = 8'h84;
  localparam logic [7:0] DDP_ADDR_P1_HI = 8'h85;
  localparam logic [7:0] DDP_ADDR_SEL = 8'h86;
  // reset values
  localparam logic [7:0] DDP_RST_BYTE = 8'h00;
  localparam logic [7:0] DDP_RST_SEL = 8'h00;
  // select flag position inside pointer_select
  localparam int DDP_SEL_BIT = 0;
  // pointer operation codes from the cpu core
  typedef enum logic [2:0] {
    DDP_OP_NONE = 3'b000,
    DDP_OP_INC = 3'b001,
    DDP_OP_LOAD = 3'b010,
    DDP_OP_CODE = 3'b011,
    DDP_OP_XRD = 3'b100,
    DDP_OP_XWR = 3'b101,
    DDP_OP_JMP = 3'b110
  } ddp_op_type;
endpackage

// [ddp_ptr.sv]
`timescale 1ns/1ns
// one 16-bit pointer with byte access and pointer-op updates
module ddp_ptr
  import ddp_pkg::*;
#(
  parameter int W = 16
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr_lo,
  input wire logic i_wr_hi,
  input wire logic [7:0] i_wdata,
  input wire logic i_chosen,
  input wire ddp_op_type i_op,
  input wire logic [W-1:0] i_imm,
  output logic [W-1:0] o_value
);
  logic [W-1:0] ptr_r; // pointer contents
  logic [W-1:0] ptr_nxt; // next contents

  // next value: byte writes, then ops on the chosen pointer
  always_comb
  begin
    ptr_nxt = ptr_r;
    if (i_wr_lo)
    begin
      ptr_nxt[7:0] = i_wdata;
    end
    if (i_wr_hi)
    begin
      ptr_nxt[W-1:8] = i_wdata;
    end
    if (i_chosen && i_op == DDP_OP_INC)
    begin
      ptr_nxt = ptr_r + W'(1);
    end
    else if (i_chosen && i_op == DDP_OP_LOAD)
    begin
      ptr_nxt = i_imm;
    end
  end

  // register the pointer
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ptr_r <= {DDP_RST_BYTE, DDP_RST_BYTE};
    end
    else
    begin
      ptr_r <= ptr_nxt;
    end
  end

  assign o_value = ptr_r;
endmodule

// [ddp_unit.sv]
`timescale 1ns/1ns
module ddp_unit
  import ddp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire ddp_op_type i_op,
  input wire logic [15:0] i_imm,
  input wire logic [7:0] i_acc,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  output logic [15:0] o_xaddr,
  output logic o_xrd,
  output logic o_xwr,
  output logic [15:0] o_code_addr,
  output logic o_code_rd,
  output logic [15:0] o_jmp_addr,
  output logic o_jmp,
  output logic o_select
);
  logic sel_r; // select flag
  logic sel_nxt; // next select flag
  logic [15:0] p0; // first pointer
  logic [15:0] p1; // second pointer
  logic [15:0] chosen; // chosen pointer
  logic [7:0] rdata_nxt; // read mux
  logic [7:0] rdata_r; // registered read data
  logic hit_r; // registered address hit
  logic hit_nxt; // decode hit
  logic [15:0] xaddr_r; // registered external address
  logic [15:0] caddr_r; // registered code address
  logic [15:0] jaddr_r; // registered jump target
  logic [15:0] xaddr_nxt;
  logic [15:0] caddr_nxt;
  logic [15:0] jaddr_nxt;
  logic xrd_r;
  logic xwr_r;
  logic crd_r;
  logic jmp_r;

  // write decode per pointer byte
  logic wr_p0_lo;
  logic wr_p0_hi;
  logic wr_p1_lo;
  logic wr_p1_hi;
  assign wr_p0_lo = i_sfr_wr && i_sfr_addr == DDP_ADDR_P0_LO;
  assign wr_p0_hi = i_sfr_wr && i_sfr_addr == DDP_ADDR_P0_HI;
  assign wr_p1_lo = i_sfr_wr && i_sfr_addr == DDP_ADDR_P1_LO;
  assign wr_p1_hi = i_sfr_wr && i_sfr_addr == DDP_ADDR_P1_HI;

  // first pointer, chosen when flag is zero
  ddp_ptr #(.W(16)) u_ptr0 (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr_lo(wr_p0_lo),
    .i_wr_hi(wr_p0_hi),
    .i_wdata(i_sfr_wdata),
    .i_chosen(!sel_r),
    .i_op(i_op),
    .i_imm(i_imm),
    .o_value(p0)
  );

  // second pointer, chosen when flag is one
  ddp_ptr #(.W(16)) u_ptr1 (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr_lo(wr_p1_lo),
    .i_wr_hi(wr_p1_hi),
    .i_wdata(i_sfr_wdata),
    .i_chosen(sel_r),
    .i_op(i_op),
    .i_imm(i_imm),
    .o_value(p1)
  );

  // chosen pointer follows the stored flag
  assign chosen = sel_r ? p1 : p0;

  // select flag next value; only bit zero is kept
  always_comb
  begin
    sel_nxt = sel_r;
    if (i_sfr_wr && i_sfr_addr == DDP_ADDR_SEL)
    begin
      sel_nxt = i_sfr_wdata[DDP_SEL_BIT];
    end
  end

  // read mux and op address outputs
  always_comb
  begin
    rdata_nxt = 8'h00;
    hit_nxt = 1'b1;
    unique case (i_sfr_addr)
      DDP_ADDR_P0_LO: rdata_nxt = p0[7:0];
      DDP_ADDR_P0_HI: rdata_nxt = p0[15:8];
      DDP_ADDR_P1_LO: rdata_nxt = p1[7:0];
      DDP_ADDR_P1_HI: rdata_nxt = p1[15:8];
      DDP_ADDR_SEL: rdata_nxt = {7'h00, sel_r};
      default: hit_nxt = 1'b0;
    endcase
    if (!i_sfr_rd)
    begin
      rdata_nxt = 8'h00;
      hit_nxt = 1'b0;
    end
    xaddr_nxt = xaddr_r;
    caddr_nxt = caddr_r;
    jaddr_nxt = jaddr_r;
    if (i_op == DDP_OP_XRD || i_op == DDP_OP_XWR)
    begin
      xaddr_nxt = chosen;
    end
    if (i_op == DDP_OP_CODE)
    begin
      caddr_nxt = chosen + {8'h00, i_acc};
    end
    if (i_op == DDP_OP_JMP)
    begin
      jaddr_nxt = chosen + {8'h00, i_acc};
    end
  end

  // registers of the top level
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sel_r <= DDP_RST_SEL[DDP_SEL_BIT];
      rdata_r <= 8'h00;
      hit_r <= 1'b0;
      xaddr_r <= 16'h0000;
      caddr_r <= 16'h0000;
      jaddr_r <= 16'h0000;
      xrd_r <= 1'b0;
      xwr_r <= 1'b0;
      crd_r <= 1'b0;
      jmp_r <= 1'b0;
    end
    else
    begin
      sel_r <= sel_nxt;
      rdata_r <= rdata_nxt;
      hit_r <= hit_nxt;
      xaddr_r <= xaddr_nxt;
      caddr_r <= caddr_nxt;
      jaddr_r <= jaddr_nxt;
      xrd_r <= i_op == DDP_OP_XRD;
      xwr_r <= i_op == DDP_OP_XWR;
      crd_r <= i_op == DDP_OP_CODE;
      jmp_r <= i_op == DDP_OP_JMP;
    end
  end

  assign o_sfr_rdata = rdata_r;
  assign o_sfr_hit = hit_r;
  assign o_xaddr = xaddr_r;
  assign o_xrd = xrd_r;
  assign o_xwr = xwr_r;
  assign o_code_addr = caddr_r;
  assign o_code_rd = crd_r;
  assign o_jmp_addr = jaddr_r;
  assign o_jmp = jmp_r;
  assign o_select = sel_r;

  // reset leaves the first pointer chosen
  sel_reset_a: assert property (
    @(posedge i_clk) i_rst |=> !sel_r)
    else $error("select not cleared by reset");
  // reserved select bits read zero
  sel_resv_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    $past(i_sfr_rd && i_sfr_addr == DDP_ADDR_SEL)
    |-> o_sfr_rdata[7:1] == 7'h00)
    else $error("reserved select bits not zero");
  // select write takes bit zero
  sel_write_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_sfr_wr && i_sfr_addr == DDP_ADDR_SEL |=> sel_r == $past(i_sfr_wdata[0]))
    else $error("select write lost");
  // increment carries over the whole word
  inc_chosen_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_op == DDP_OP_INC && !i_sfr_wr
    |=> chosen == $past(chosen) + 16'h0001)
    else $error("increment wrong");
  // increment leaves the other pointer alone
  inc_other_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_op == DDP_OP_INC && !i_sfr_wr
    |=> (sel_r ? p0 : p1) == $past(sel_r ? p0 : p1))
    else $error("other pointer changed");
  // immediate load hits chosen pointer only
  load_only_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_op == DDP_OP_LOAD && !i_sfr_wr
    |=> chosen == $past(i_imm) && (sel_r ? p0 : p1) == $past(sel_r ? p0 : p1))
    else $error("immediate load wrong");
  // external address is the chosen pointer
  xaddr_ptr_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_op == DDP_OP_XRD |=> o_xrd && o_xaddr == $past(chosen))
    else $error("external address wrong");
  // byte write lands regardless of selection
  byte_write_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    wr_p1_hi && i_op == DDP_OP_NONE |=> p1[15:8] == $past(i_sfr_wdata))
    else $error("byte write lost");
  // byte read returns pointer contents
  byte_read_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_sfr_rd && i_sfr_addr == DDP_ADDR_P0_LO |=> o_sfr_rdata == $past(p0[7:0]))
    else $error("byte read wrong");
endmodule

// [dual_data_pointer_unit_bench.sv]
`timescale 1ns/1ns
// self-checking bench for the dual pointer unit
module dual_data_pointer_unit_bench
  import ddp_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic wr, rd, hit, xrd, xwr, crd, jmp, so;
  logic [7:0] addr, wdata, acc, rdata;
  logic [15:0] imm, xaddr, caddr, jaddr;
  ddp_op_type op;
  logic [15:0] p [2]; // expected pointers
  logic s; // expected select flag
  int errors = 0;
  int n_checks = 0;
  int cyc_n = 0;
  ddp_cpu_model ddp_cpu_model_i (.i_clk(i_clk), .o_wr(wr), .o_rd(rd),
    .o_addr(addr), .o_wdata(wdata), .o_op(op), .o_imm(imm), .o_acc(acc));
  ddp_unit ddp_unit_i (.i_clk(i_clk), .i_rst(i_rst), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .i_sfr_addr(addr), .i_sfr_wdata(wdata), .i_op(op),
    .i_imm(imm), .i_acc(acc), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
    .o_xaddr(xaddr), .o_xrd(xrd), .o_xwr(xwr), .o_code_addr(caddr),
    .o_code_rd(crd), .o_jmp_addr(jaddr), .o_jmp(jmp), .o_select(so));
  // 100 ns clock
  initial
  begin
    forever #50 i_clk = ~i_clk;
  end
  // hang guard
  always @(posedge i_clk)
  begin
    cyc_n++;
    if (cyc_n == 3000)
    begin
      errors++;
      $display("[FAIL] timeout exp done got hang");
      close_out();
    end
  end
  // pointer value after an op
  function automatic logic [15:0] nxt(ddp_op_type o, logic [15:0] v,
    logic [15:0] m);
    if (o == DDP_OP_INC)
      return v + 16'h0001;
    return (o == DDP_OP_LOAD) ? m : v;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic sfr(input logic w, input logic r, input logic [7:0] a,
    input logic [7:0] d);
    ddp_cpu_model_i.cyc(w, r, a, d, DDP_OP_NONE, '0, '0);
  endtask
  // read one sfr, answer registered at the taking edge, one cycle after launch
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
    input logic h);
    sfr(1'b0, 1'b1, a, '0);
    sfr(1'b0, 1'b0, '0, '0);
    #1;
    chk("rdata", {8'h00, e}, {8'h00, rdata});
    chk("hit", {15'h0, h}, {15'h0, hit});
  endtask
  // all five registers plus an unmapped place
  task automatic chk_all();
    rd_chk(DDP_ADDR_P0_LO, p[0][7:0], 1'b1);
    rd_chk(DDP_ADDR_P0_HI, p[0][15:8], 1'b1);
    rd_chk(DDP_ADDR_P1_LO, p[1][7:0], 1'b1);
    rd_chk(DDP_ADDR_P1_HI, p[1][15:8], 1'b1);
    rd_chk(DDP_ADDR_SEL, {7'h00, s}, 1'b1);
    rd_chk(8'h87, 8'h00, 1'b0);
  endtask
  // select write, then op on the very next cycle
  task automatic do_op(input ddp_op_type o, input logic ns,
    input logic [7:0] up);
    logic [15:0] m;
    logic [7:0] c;
    m = 16'($urandom);
    c = 8'($urandom);
    sfr(1'b1, 1'b0, DDP_ADDR_SEL, {up[7:1], ns});
    s = ns;
    ddp_cpu_model_i.cyc(1'b0, 1'b0, '0, '0, o, m, c);
    sfr(1'b0, 1'b0, '0, '0);
    #1;
    chk("pulses", {12'h0, o == DDP_OP_XRD, o == DDP_OP_XWR,
      o == DDP_OP_CODE, o == DDP_OP_JMP}, {12'h0, xrd, xwr, crd, jmp});
    if (o == DDP_OP_XRD || o == DDP_OP_XWR)
      chk("xaddr", p[s], xaddr);
    if (o == DDP_OP_CODE)
      chk("code", p[s] + {8'h00, c}, caddr);
    if (o == DDP_OP_JMP)
      chk("jump", p[s] + {8'h00, c}, jaddr);
    chk("select", {15'h0, s}, {15'h0, so});
    p[s] = nxt(o, p[s], m);
  endtask
  // main sequence
  initial
  begin
    void'($urandom(58));
    p = '{16'h0000, 16'h0000};
    s = 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    chk_all();
    $display("test reset done");
    sfr(1'b1, 1'b0, DDP_ADDR_SEL, 8'hFF);
    sfr(1'b1, 1'b0, DDP_ADDR_P0_LO, 8'hFF);
    sfr(1'b1, 1'b0, DDP_ADDR_P0_HI, 8'hFF);
    sfr(1'b1, 1'b0, DDP_ADDR_P1_LO, 8'hFF);
    sfr(1'b1, 1'b0, DDP_ADDR_P1_HI, 8'h00);
    s = 1'b1;
    p = '{16'hFFFF, 16'h00FF};
    chk_all();
    do_op(DDP_OP_INC, 1'b0, 8'hFE);
    do_op(DDP_OP_INC, 1'b1, 8'h00);
    chk_all();
    $display("test carry done");
    for (int i = 1; i < 7; i++)
      do_op(ddp_op_type'(i), 1'(i), 8'($urandom));
    for (int i = 0; i < 40; i++)
      do_op(ddp_op_type'($urandom_range(6, 0)), 1'($urandom),
        8'($urandom));
    // corner: select write and increment in one cycle use the old choice
    ddp_cpu_model_i.cyc(1'b1, 1'b0, DDP_ADDR_SEL, {7'h00, ~s}, DDP_OP_INC,
      '0, '0);
    p[s] = nxt(DDP_OP_INC, p[s], '0);
    s = ~s;
    // corner: load beats a byte write to the same pointer
    ddp_cpu_model_i.cyc(1'b1, 1'b0, s ? DDP_ADDR_P1_LO : DDP_ADDR_P0_LO,
      8'h5A, DDP_OP_LOAD, 16'h1234, '0);
    p[s] = nxt(DDP_OP_LOAD, p[s], 16'h1234);
    chk_all();
    $display("test random ops done");
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    p = '{16'h0000, 16'h0000};
    s = 1'b0;
    chk_all();
    $display("test second reset done");
    close_out();
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
endmodule
